// *** design/serial_port_config_regs.sv ***
// Serial control port configuration, identification and readback registers.
// Assumes host drives chip select, serial clock (idle low) and data pins;
// bytes are written on rising edges, read data changes on falling edges.
`include "spi_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs (
    input wire logic core_clk_i, // Core clock, 10 MHz
    input wire logic rst_i, // Async reset, active high
    input wire logic csb_n_i, // Chip select pin, active low
    input wire logic sclk_i, // Serial clock pin
    input wire logic sdio_i, // Bidirectional data pin, input side
    output logic sdio_o, // Bidirectional data pin, output side
    output logic sdio_oe_n_o, // Bidirectional pin drive, low drives
    output logic serial_output_pin_o, // Dedicated output pin data
    output logic serial_output_pin_oe_n_o, // Dedicated pin drive, low drives
    output logic [7:0] active_port_cfg_o, // Active configuration copy
    output logic [7:0] active_readback_sel_o, // Active readback select copy
    output logic soft_reset_o // Soft reset level to the core
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        spi_cfg_pkg::phase_t ph; // Frame phase
        logic [4:0] cnt; // Bits in current field
        logic [15:0] sh; // Shift register
        logic rd; // Frame is a read
        logic [11:0] addr; // Current register address
        logic [7:0] rdb; // Read byte being shifted out
        logic drive; // Read data being driven
        logic dout; // Output bit
        spi_cfg_pkg::byte_t buf_cfg; // Buffered configuration
        spi_cfg_pkg::byte_t buf_rbs; // Buffered readback select
        spi_cfg_pkg::byte_t act_cfg; // Active configuration
        spi_cfg_pkg::byte_t act_rbs; // Active readback select
        logic sdio_oe_n; // Bidirectional pin enable
        logic sdo_oe_n; // Dedicated pin enable
    } regs_state_t;

    regs_state_t q, d;
    pin_sync_if sync ();

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    pin_front u_front (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .csb_n_i(csb_n_i),
        .sclk_i(sclk_i),
        .sdio_i(sdio_i),
        .sync(sync)
    );

    // Readback mux for one register address
    function automatic logic [7:0] read_reg(input logic [11:0] a, input regs_state_t s);
        logic use_act;
        use_act = s.buf_rbs[`BIT_READBACK_ACTIVE];
        read_reg = 8'h00;
        unique case (a)
            `ADDR_PORT_CFG: read_reg = use_act ? s.act_cfg : s.buf_cfg;
            `ADDR_VARIANT_ID: read_reg = `VARIANT_ID_VALUE;
            `ADDR_READBACK_SEL: read_reg = use_act ? s.act_rbs : s.buf_rbs;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        logic lsb;
        logic [15:0] ns;
        logic [7:0] wb;
        logic [11:0] ia;
        lsb = q.buf_cfg[`BIT_LSB_FIRST];
        ns = 16'h0000;
        wb = 8'h00;
        ia = 12'h000;
        d = q;
        if (sync.csb_n) begin
            // Deselected: end frame, release pins
            d.ph = spi_cfg_pkg::PH_INSTR;
            d.cnt = 5'h00;
            d.drive = 1'b0;
        end else if (sync.sclk_rise && q.ph != spi_cfg_pkg::PH_IDLE) begin
            // Shift in at the bit order chosen
            ns = lsb ? {sync.sdio, q.sh[15:1]} : {q.sh[14:0], sync.sdio};
            d.sh = ns;
            d.cnt = q.cnt + 5'h01;
            if (q.ph == spi_cfg_pkg::PH_INSTR && q.cnt == 5'(`LONG_INSTR_BITS - 1)) begin
                // Long instruction only; length bit read but not honoured
                // Either shift direction leaves the word in instruction order:
                // R/W on top, address in the low twelve bits
                ia = ns[11:0];
                d.rd = ns[15];
                d.addr = ia;
                d.ph = spi_cfg_pkg::PH_DATA;
                d.cnt = 5'h00;
                d.rdb = read_reg(d.addr, q);
            end else if (q.ph == spi_cfg_pkg::PH_DATA && q.cnt == 5'(`DATA_BITS - 1)) begin
                wb = lsb ? ns[15:8] : ns[7:0];
                d.cnt = 5'h00;
                if (!q.rd) begin
                    unique case (q.addr)
                        `ADDR_PORT_CFG: d.buf_cfg = wb;
                        `ADDR_READBACK_SEL: d.buf_rbs = wb;
                        `ADDR_UPDATE_ALL: begin
                            // Pulse only: copy buffered to active
                            if (wb[`BIT_UPDATE_ALL]) begin
                                d.act_cfg = q.buf_cfg;
                                d.act_rbs = q.buf_rbs;
                            end
                        end
                        default: ; // Identifier and unmapped: dropped
                    endcase
                end
                // Next address by bit order
                d.addr = lsb ? q.addr + 12'h001 : q.addr - 12'h001;
                d.rdb = read_reg(d.addr, d);
            end
        end else if (sync.sclk_fall && q.rd && q.ph == spi_cfg_pkg::PH_DATA) begin
            // Present next read bit on falling edge
            d.drive = 1'b1;
            d.dout = lsb ? q.rdb[q.cnt[2:0]] : q.rdb[3'h7 - q.cnt[2:0]];
        end
        // Pin selection for read data
        d.sdio_oe_n = ~(d.drive & ~q.buf_cfg[`BIT_OUT_PIN_SEL]);
        d.sdo_oe_n = ~(d.drive & q.buf_cfg[`BIT_OUT_PIN_SEL]);
        // Soft reset: defaults held while bit stays set; soft reset bit and bit 5 kept
        if (q.buf_cfg[`BIT_SOFT_RESET]) begin
            d.buf_cfg = {`RST_PORT_CFG} | (d.buf_cfg & 8'h24);
            d.buf_rbs = `RST_READBACK_SEL;
            d.act_cfg = `RST_PORT_CFG;
            d.act_rbs = `RST_READBACK_SEL;
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{ph: spi_cfg_pkg::PH_INSTR, cnt: 5'h00, sh: 16'h0000, rd: 1'b0,
                   addr: 12'h000, rdb: 8'h00, drive: 1'b0, dout: 1'b0,
                   buf_cfg: `RST_PORT_CFG, buf_rbs: `RST_READBACK_SEL,
                   act_cfg: `RST_PORT_CFG, act_rbs: `RST_READBACK_SEL,
                   sdio_oe_n: 1'b1, sdo_oe_n: 1'b1};
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs straight from flip-flops
    // ---------------------------------------------------------------
    assign sdio_o = q.dout;
    assign sdio_oe_n_o = q.sdio_oe_n;
    assign serial_output_pin_o = q.dout;
    assign serial_output_pin_oe_n_o = q.sdo_oe_n;
    assign active_port_cfg_o = q.act_cfg;
    assign active_readback_sel_o = q.act_rbs;
    assign soft_reset_o = q.buf_cfg[`BIT_SOFT_RESET];
endmodule
`default_nettype wire

// *** design/spi_cfg_map.svh ***
// Register map constants of the serial port configuration block.
// Assumes inclusion by bare name; definitions only.
`ifndef SPI_CFG_MAP_SVH
`define SPI_CFG_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (12-bit serial address)
// ---------------------------------------------------------------
`define ADDR_PORT_CFG 12'h000
`define ADDR_VARIANT_ID 12'h003
`define ADDR_READBACK_SEL 12'h004
`define ADDR_UPDATE_ALL 12'h232

// ---------------------------------------------------------------
// Field positions of the port configuration, readback select and update registers
// ---------------------------------------------------------------
`define BIT_OUT_PIN_SEL 0
`define BIT_LSB_FIRST 1
`define BIT_SOFT_RESET 2
`define BIT_LONG_INSTR 3
`define BIT_READBACK_ACTIVE 0
`define BIT_UPDATE_ALL 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_PORT_CFG 8'h18
`define RST_READBACK_SEL 8'h00
`define RST_UPDATE_ALL 8'h00
// Variant identifier; value is arbitrary
`define VARIANT_ID_VALUE 8'h5A

// ---------------------------------------------------------------
// Frame sizes
// ---------------------------------------------------------------
`define LONG_INSTR_BITS 16
`define SHORT_INSTR_BITS 8
`define DATA_BITS 8

`endif

// *** design/spi_cfg_pkg.sv ***
// Types shared by the serial port configuration block.
// Assumes spi_cfg_map.svh constants are used alongside.
package spi_cfg_pkg;

    // Serial frame phases
    typedef enum logic [2:0] {
        PH_INSTR = 3'b001,
        PH_DATA = 3'b010,
        PH_IDLE = 3'b100
    } phase_t;

    // One register byte of the buffered/active pair
    typedef logic [7:0] byte_t;

endpackage

// *** design/pin_sync_if.sv ***
// Carrier for synchronised serial port pin levels and edges.
// Assumes one clock domain shared by producer and consumer.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
    logic csb_n; // Synchronised chip select, active low
    logic sclk_rise; // One-cycle pulse on serial clock rise
    logic sclk_fall; // One-cycle pulse on serial clock fall
    logic sdio; // Synchronised data in level
    modport src (output csb_n, output sclk_rise, output sclk_fall, output sdio);
    modport dst (input csb_n, input sclk_rise, input sclk_fall, input sdio);
endinterface
`default_nettype wire

// *** design/pin_sync3.sv ***
// Three-stage synchroniser for one pin; level changes once stage 2 and 3 agree.
// Assumes asynchronous pin input and core clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
    parameter logic INIT = 1'b0 // Idle level after reset
) (
    input wire logic core_clk_i, // Core clock
    input wire logic rst_i, // Async reset, active high
    input wire logic pin_i, // Raw pin
    output logic level_o, // Filtered level
    output logic rise_o, // One-cycle rise pulse
    output logic fall_o // One-cycle fall pulse
);
    typedef struct packed {
        logic [2:0] st; // Shift stages
        logic lvl; // Accepted level
        logic rise; // Rise pulse
        logic fall; // Fall pulse
    } sync_state_t;

    sync_state_t q, d;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        d.st = {q.st[1:0], pin_i};
        d.rise = 1'b0;
        d.fall = 1'b0;
        // Accept change only when stage 2 and 3 agree
        if (q.st[1] == q.st[2] && q.st[2] != q.lvl) begin
            d.lvl = q.st[2];
            d.rise = q.st[2];
            d.fall = ~q.st[2];
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{st: {3{INIT}}, lvl: INIT, rise: 1'b0, fall: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign level_o = q.lvl;
    assign rise_o = q.rise;
    assign fall_o = q.fall;
endmodule
`default_nettype wire

// *** design/pin_front.sv ***
// Pin front end: synchronises chip select, serial clock and data in.
// Assumes raw pins from the host controller.
`timescale 1ns/1ps
`default_nettype none
module pin_front (
    input wire logic core_clk_i, // Core clock
    input wire logic rst_i, // Async reset
    input wire logic csb_n_i, // Raw chip select
    input wire logic sclk_i, // Raw serial clock
    input wire logic sdio_i, // Raw data in
    pin_sync_if.src sync // Synchronised outputs
);
    // ---------------------------------------------------------------
    // One synchroniser per pin
    // ---------------------------------------------------------------
    pin_sync3 #(.INIT(1'b1)) u_cs (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .pin_i(csb_n_i),
        .level_o(sync.csb_n), .rise_o(), .fall_o()
    );
    pin_sync3 #(.INIT(1'b0)) u_ck (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .pin_i(sclk_i),
        .level_o(), .rise_o(sync.sclk_rise), .fall_o(sync.sclk_fall)
    );
    pin_sync3 #(.INIT(1'b0)) u_sd (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .pin_i(sdio_i),
        .level_o(sync.sdio), .rise_o(), .fall_o()
    );
endmodule
`default_nettype wire

// *** testbench/spi_host_model.sv ***
// Host controller model driving the serial control port pins.
// Assumes the bench calls frame() on a falling core clock edge.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic csb_n_o, // Chip select, active low
    output logic sclk_o, // Serial clock, idle low
    output logic sdio_o, // Host side of the data pin
    input wire logic dev_sdio_i, // Resolved data pin level
    input wire logic out_pin_i // Device dedicated output pin
);
    // Idle pins at time zero
    initial begin
        csb_n_o = 1'b1;
        sclk_o = 1'b0;
        sdio_o = 1'b0;
    end
    // One bit: 600 ns low then 600 ns high; sample just before the rise
    task automatic bit_xfer(input logic d, input logic uni, output logic q);
        sdio_o = d;
        #600;
        q = uni ? out_pin_i : dev_sdio_i;
        sclk_o = 1'b1;
        #600;
        sclk_o = 1'b0;
    endtask
    // Whole frame: instruction then n bytes, byte b in bits of wd/rd
    task automatic frame(input logic [15:0] ins, input int n, input logic [15:0] wd,
                         input logic lsb, input logic uni, output logic [15:0] rd);
        logic q;
        int k;
        csb_n_o = 1'b0;
        #600;
        for (int i = 0; i < 16; i++) begin
            bit_xfer(ins[lsb ? i : 15 - i], uni, q);
        end
        for (int b = 0; b < n; b++) begin
            for (int i = 0; i < 8; i++) begin
                k = (1 - b) * 8 + (lsb ? i : 7 - i);
                // Released line toggles during reads so a stale value never passes
                bit_xfer(ins[15] ? ~sdio_o : wd[k], uni, q);
                rd[k] = q;
            end
        end
        csb_n_o = 1'b1;
        #1200;
    endtask
endmodule
`default_nettype wire

// *** testbench/serial_port_config_regs_assertions.sv ***
// Checker of the serial port configuration block, bound to its top.
// Assumes host pins stay idle between frames.
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs_assertions (
    input wire logic core_clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic csb_n_i, // Select
    input wire logic sclk_i, // Serial clock
    input wire logic sdio_i, // Data in
    input wire logic sdio_o, // Data out
    input wire logic sdio_oe_n_o, // Data drive
    input wire logic serial_output_pin_o, // Pin data
    input wire logic serial_output_pin_oe_n_o, // Pin drive
    input wire logic [7:0] active_port_cfg_o, // Active cfg
    input wire logic [7:0] active_readback_sel_o, // Active select
    input wire logic soft_reset_o // Soft reset
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // Select idle long enough to pass the synchroniser
    sequence s_idle;
        csb_n_i [*6];
    endsequence
    property p_rst_cfg;
        $fell(rst_i) |-> active_port_cfg_o == 8'h18 && !soft_reset_o;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("cfg not default");
    property p_rst_pins;
        $fell(rst_i) |-> sdio_oe_n_o && serial_output_pin_oe_n_o && active_readback_sel_o == 8'h00;
    endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins not idle");
    property p_oe_excl;
        !serial_output_pin_oe_n_o |-> sdio_oe_n_o;
    endproperty
    a_oe_excl: assert property (p_oe_excl) else $error("both pins driven");
    property p_same_data;
        !sdio_oe_n_o |-> sdio_o == serial_output_pin_o;
    endproperty
    a_same_data: assert property (p_same_data) else $error("read data differs");
    property p_idle_float;
        s_idle |=> sdio_oe_n_o && serial_output_pin_oe_n_o;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("pin driven idle");
    property p_hold;
        s_idle |=> $stable(soft_reset_o) && $stable(active_port_cfg_o) && $stable(active_readback_sel_o);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved idle");
    property p_act_in_frame;
        $changed(active_port_cfg_o) || $changed(active_readback_sel_o) |-> !$past(csb_n_i, 2);
    endproperty
    a_act_in_frame: assert property (p_act_in_frame) else $error("copy outside frame");
    property p_soft_in_frame;
        $changed(soft_reset_o) |-> !$past(csb_n_i, 2);
    endproperty
    a_soft_in_frame: assert property (p_soft_in_frame) else $error("soft reset stray");
endmodule
bind serial_port_config_regs serial_port_config_regs_assertions u_sva (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .csb_n_i(csb_n_i), .sclk_i(sclk_i),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o),
    .serial_output_pin_o(serial_output_pin_o), .serial_output_pin_oe_n_o(serial_output_pin_oe_n_o),
    .active_port_cfg_o(active_port_cfg_o), .active_readback_sel_o(active_readback_sel_o),
    .soft_reset_o(soft_reset_o));
`default_nettype wire

// *** testbench/tb_serial_port_config_regs.sv ***
// Self-checking bench of the serial port configuration block.
// Assumes the host model and the bound checker beside the design.
`include "spi_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_config_regs;
    logic core_clk_i = 1'b0; // 10 MHz clock
    logic rst_i = 1'b1; // Reset, held at start
    logic csb_n, sclk, host_sdio, line, dev_sdio, dev_oe_n, pin, pin_oe_n, soft_rst;
    logic [7:0] act_cfg, act_rbs; // Active copies
    logic [7:0] m_cfg = 8'h18, m_rbs = 8'h00, a_cfg = 8'h18, a_rbs = 8'h00; // Model
    logic [15:0] rd; // Read bytes of the last frame
    logic [11:0] ua; // Random unmapped address
    int n_mismatch = 0, cmp_count = 0, cycles = 0, seed = 39;
    always #50 core_clk_i = ~core_clk_i;
    // Shared data pin: device wins while its drive is low
    assign line = dev_oe_n ? host_sdio : dev_sdio;
    serial_port_config_regs u_serial_port_config_regs (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .csb_n_i(csb_n), .sclk_i(sclk), .sdio_i(line), .sdio_o(dev_sdio), .sdio_oe_n_o(dev_oe_n),
        .serial_output_pin_o(pin), .serial_output_pin_oe_n_o(pin_oe_n),
        .active_port_cfg_o(act_cfg), .active_readback_sel_o(act_rbs), .soft_reset_o(soft_rst));
    spi_host_model u_spi_host_model (.csb_n_o(csb_n), .sclk_o(sclk), .sdio_o(host_sdio),
        .dev_sdio_i(line), .out_pin_i(pin));
    // Hang guard
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Model read: bank chosen by buffered select bit
    function automatic logic [7:0] m_rd(input logic [11:0] a);
        if (a == `ADDR_PORT_CFG) return m_rbs[0] ? a_cfg : m_cfg;
        if (a == `ADDR_VARIANT_ID) return `VARIANT_ID_VALUE;
        if (a == `ADDR_READBACK_SEL) return m_rbs[0] ? a_rbs : m_rbs;
        return 8'h00;
    endfunction
    // Model write: soft reset clears select, update copies banks
    function automatic void m_wr(input logic [11:0] a, input logic [7:0] d);
        if (a == `ADDR_PORT_CFG) m_cfg = d;
        if (a == `ADDR_PORT_CFG && d[2]) begin
            m_rbs = 8'h00;
            a_cfg = 8'h18;
            a_rbs = 8'h00;
        end
        if (a == `ADDR_READBACK_SEL) m_rbs = d;
        if (a == `ADDR_UPDATE_ALL && d[0]) begin
            a_cfg = m_cfg;
            a_rbs = m_rbs;
        end
    endfunction
    // One frame, then per-byte model update or compare with address stepping
    task automatic xfer(input logic rw, input logic [11:0] a, input int n, input logic [15:0] wd);
        logic lsb;
        lsb = m_cfg[1];
        u_spi_host_model.frame({rw, 3'b000, a}, n, wd, lsb, m_cfg[0], rd);
        for (int b = 0; b < n; b++) begin
            if (rw) chk(rd[15 - 8 * b -: 8], m_rd(lsb ? a + 12'(b) : a - 12'(b)));
            else m_wr(lsb ? a + 12'(b) : a - 12'(b), wd[15 - 8 * b -: 8]);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence, all stimulus on falling edges
    initial begin
        repeat (16) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (6) @(negedge core_clk_i);
        chk(act_cfg, 8'h18);
        xfer(1, `ADDR_PORT_CFG, 1, 16'h0000);
        xfer(0, `ADDR_VARIANT_ID, 1, {8'($random(seed)), 8'h00});
        xfer(1, `ADDR_READBACK_SEL, 2, 16'h0000);
        ua = {4'h1, 8'($random(seed))};
        xfer(0, ua, 1, 16'hFF00);
        xfer(1, ua, 1, 16'h0000);
        xfer(0, `ADDR_READBACK_SEL, 1, 16'h0100);
        xfer(1, `ADDR_READBACK_SEL, 1, 16'h0000);
        xfer(0, `ADDR_UPDATE_ALL, 1, 16'h0100);
        chk(act_rbs, 8'h01);
        xfer(1, `ADDR_UPDATE_ALL, 1, 16'h0000);
        xfer(0, `ADDR_READBACK_SEL, 1, 16'h0000);
        xfer(1, `ADDR_READBACK_SEL, 1, 16'h0000);
        xfer(0, `ADDR_PORT_CFG, 1, 16'h5A00);
        xfer(1, `ADDR_VARIANT_ID, 2, 16'h0000);
        xfer(0, `ADDR_UPDATE_ALL, 1, 16'h0100);
        chk(act_cfg, 8'h5A);
        xfer(0, `ADDR_PORT_CFG, 1, 16'hDB00);
        xfer(1, `ADDR_VARIANT_ID, 1, 16'h0000);
        xfer(0, `ADDR_PORT_CFG, 1, 16'h1800);
        xfer(0, `ADDR_READBACK_SEL, 1, 16'h0100);
        xfer(0, `ADDR_PORT_CFG, 1, 16'h3C00);
        chk({7'h00, soft_rst}, 8'h01);
        xfer(1, `ADDR_READBACK_SEL, 1, 16'h0000);
        xfer(0, `ADDR_PORT_CFG, 1, 16'h1800);
        chk({7'h00, soft_rst}, 8'h00);
        xfer(1, `ADDR_PORT_CFG, 1, 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
